// ---- verilog/uvpc_consts.vh ----
// Constants for the memory programming and read controller.
// Assumes inclusion by bare name from the controller design files.
// Functional notes
// - Programming needs raised supply and select/strobe driven low.
// - Within a programming operation, select/strobe is low only for the write pulse.
// - Address and data byte are presented during programming.
// - Single-shot programming uses one 10 ms pulse per location.
// - Never switch the programming supply while select and strobe are low.
// - Signature read: bit 9 high voltage, select/enable low, others low; the code drives bit 0 from the request.
`ifndef UVPC_CONSTS_VH
`define UVPC_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define UVPC_ADDR_W 15
`define UVPC_DATA_W 8
`define UVPC_ERASED_BYTE 8'hFF

// ----------------------------------------
// Timing, in ns, and cycle counts at 10 ns
// ----------------------------------------
`define UVPC_CLK_NS 10
`define UVPC_T_SETUP_NS 2000
`define UVPC_T_PULSE_NS 10000000
`define UVPC_T_ACCESS_NS 130
`define UVPC_T_FLOAT_NS 130
`define UVPC_SETUP_CYC \
  ((`UVPC_T_SETUP_NS + `UVPC_CLK_NS - 1) / `UVPC_CLK_NS)
`define UVPC_PULSE_CYC (`UVPC_T_PULSE_NS / `UVPC_CLK_NS)
`define UVPC_ACCESS_CYC \
  ((`UVPC_T_ACCESS_NS + `UVPC_CLK_NS - 1) / `UVPC_CLK_NS)
`define UVPC_FLOAT_CYC \
  ((`UVPC_T_FLOAT_NS + `UVPC_CLK_NS - 1) / `UVPC_CLK_NS)
`define UVPC_CNT_W 24

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define UVPC_OP_READ 2'h0
`define UVPC_OP_PROG 2'h1
`define UVPC_OP_SIG 2'h2
`define UVPC_OP_VERIFY 2'h3

`endif

// ---- verilog/uvpc_sync.v ----
// Two flip-flop synchroniser for a bus of pin inputs.
// Assumes the pins are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module uvpc_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;

  // First stage feeds only the second
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/uvpc_ctrl.v ----
// Host controller that reads, programs, verifies and reads the signature
// of a 32K x 8 erasable memory through its pins.
// Assumes pin inputs are asynchronous and the supply switches are external.
`timescale 1ns/100ps
`default_nettype none
`include "uvpc_consts.vh"
module uvpc_ctrl #(
  parameter PULSE_CYC = `UVPC_PULSE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // User request
  input wire req_valid,
  input wire [1:0] req_op,
  input wire [`UVPC_ADDR_W-1:0] req_addr,
  input wire [`UVPC_DATA_W-1:0] req_wdata,
  output reg req_ready,
  // User answer
  output reg rsp_valid,
  output reg [`UVPC_DATA_W-1:0] rsp_rdata,
  output reg rsp_error,
  // Memory pins
  output reg [`UVPC_ADDR_W-1:0] mem_addr,
  output reg select_and_program_strobe_n,
  output reg output_enable_n,
  output reg prog_supply_high,
  output reg signature_select_hv,
  output reg [`UVPC_DATA_W-1:0] mem_dq_out,
  output reg mem_dq_oe_n,
  input wire [`UVPC_DATA_W-1:0] mem_dq_in
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_ACCESS = 3'h2;
  localparam S_PULSE = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam S_FLOAT = 3'h5;
  localparam S_DONE = 3'h6;

  // ----------------------------------------
  // Counter loads
  // ----------------------------------------
  // Kept as integers and cut to the counter width where loaded; the
  // longest load, the write pulse at its default, still fits 24 bits.
  localparam integer SETUP_CNT = `UVPC_SETUP_CYC;
  localparam integer ACCESS_CNT = `UVPC_ACCESS_CYC + 2; // Two sync flops
  localparam integer FLOAT_CNT = `UVPC_FLOAT_CYC + `UVPC_SETUP_CYC;

  reg [2:0] state_reg;
  reg [1:0] op_reg;
  reg [`UVPC_CNT_W-1:0] cnt_reg;
  reg [`UVPC_DATA_W-1:0] wdata_reg;
  wire [`UVPC_DATA_W-1:0] dq_sync;
  wire req_take;
  wire req_is_prog;
  wire req_is_sig;
  wire req_raises_supply;
  wire op_is_prog;
  wire op_is_verify;
  wire verify_miss;
  wire cnt_last;

  // ----------------------------------------
  // Request and operation decode
  // ----------------------------------------
  // Verify raises the supply as program does, since the device only
  // hands a byte back for checking while the supply stands raised.
  assign req_take = req_valid && req_ready;
  assign req_is_prog = (req_op == `UVPC_OP_PROG);
  assign req_is_sig = (req_op == `UVPC_OP_SIG);
  assign req_raises_supply = req_is_prog || (req_op == `UVPC_OP_VERIFY);
  assign op_is_prog = (op_reg == `UVPC_OP_PROG);
  assign op_is_verify = (op_reg == `UVPC_OP_VERIFY);
  // A verify miss flags the byte; programming only clears bits
  assign verify_miss = op_is_verify && (dq_sync != wdata_reg);
  // Counters load N and stop at one, so each phase lasts N cycles
  assign cnt_last = (cnt_reg <= 1);

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  // Data pins pass two flops before use
  uvpc_sync #(
    .W(`UVPC_DATA_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(mem_dq_in),
    .sync_out(dq_sync)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Idle parks the pins in standby: select high with the supply low floats the device outputs
  // whatever enable does, so bus contention cannot occur between ops.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      op_reg <= `UVPC_OP_READ;
      cnt_reg <= {`UVPC_CNT_W{1'b0}};
      wdata_reg <= {`UVPC_DATA_W{1'b0}};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {`UVPC_DATA_W{1'b0}};
      rsp_error <= 1'b0;
      mem_addr <= {`UVPC_ADDR_W{1'b0}};
      select_and_program_strobe_n <= 1'b1;
      output_enable_n <= 1'b1;
      prog_supply_high <= 1'b0;
      signature_select_hv <= 1'b0;
      mem_dq_out <= {`UVPC_DATA_W{1'b0}};
      mem_dq_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        // Ready only here, so a request during an op waits its turn
        S_IDLE: begin
          req_ready <= 1'b1;
          if (req_take) begin
            req_ready <= 1'b0;
            op_reg <= req_op;
            wdata_reg <= req_wdata;
            cnt_reg <= SETUP_CNT[`UVPC_CNT_W-1:0];
            state_reg <= S_SETUP;
            if (req_is_sig) begin
              // Only bit 0 follows the request; others held low
              mem_addr <= {{(`UVPC_ADDR_W-1){1'b0}}, req_addr[0]};
              signature_select_hv <= 1'b1;
            end else begin
              mem_addr <= req_addr;
            end
            // Supply is raised while select is still high
            if (req_raises_supply) begin
              prog_supply_high <= 1'b1;
            end
            if (req_is_prog) begin
              mem_dq_out <= req_wdata;
              mem_dq_oe_n <= 1'b0;
            end
          end
        end
        S_SETUP: begin
          // Address, data and supply settle before any strobe
          if (cnt_last) begin
            if (op_is_prog) begin
              // Enable high with select low is program mode
              select_and_program_strobe_n <= 1'b0;
              cnt_reg <= PULSE_CYC[`UVPC_CNT_W-1:0];
              state_reg <= S_PULSE;
            end else begin
              // Select and enable low: read, verify or signature
              select_and_program_strobe_n <= 1'b0;
              output_enable_n <= 1'b0;
              cnt_reg <= ACCESS_CNT[`UVPC_CNT_W-1:0];
              state_reg <= S_ACCESS;
            end
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_PULSE: begin
          // Exactly one pulse, strobe held low throughout
          if (cnt_last) begin
            select_and_program_strobe_n <= 1'b1;
            cnt_reg <= SETUP_CNT[`UVPC_CNT_W-1:0];
            state_reg <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_HOLD: begin
          // Data hold after strobe rises, then release the bus
          if (cnt_last) begin
            mem_dq_oe_n <= 1'b1;
            cnt_reg <= SETUP_CNT[`UVPC_CNT_W-1:0];
            state_reg <= S_FLOAT;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_ACCESS: begin
          // Access time plus two synchroniser cycles
          if (cnt_last) begin
            rsp_rdata <= dq_sync;
            rsp_error <= verify_miss;
            select_and_program_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            cnt_reg <= FLOAT_CNT[`UVPC_CNT_W-1:0];
            state_reg <= S_FLOAT;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        S_FLOAT: begin
          // Device floats and supply drops only with select high
          if (cnt_last) begin
            prog_supply_high <= 1'b0;
            signature_select_hv <= 1'b0;
            state_reg <= S_DONE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        // Answer pulse; a write reports the byte it placed on the pins
        S_DONE: begin
          if (op_is_prog) begin
            rsp_error <= 1'b0;
            rsp_rdata <= wdata_reg;
          end
          rsp_valid <= 1'b1;
          state_reg <= S_IDLE;
        end
        // Unused codes fall back to idle with the pins left as they stand
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verification/uvpc_asserts.sv ----
// Pin sequencing checks for the memory controller.
// Assumes binding into uvpc_ctrl; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module uvpc_asserts #(
  parameter PULSE_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Answer and memory pins
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [14:0] mem_addr,
  input wire logic select_and_program_strobe_n,
  input wire logic output_enable_n,
  input wire logic prog_supply_high,
  input wire logic signature_select_hv,
  input wire logic mem_dq_oe_n
);
  wire pgm_lo = !select_and_program_strobe_n;
  int pulse_cnt;
  // Length of the strobe pulse in write mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pulse_cnt <= 0;
    else
      pulse_cnt <= (pgm_lo && output_enable_n) ? pulse_cnt + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_WRITE_ENTRY:
    assert property (pgm_lo && output_enable_n |-> prog_supply_high)
    else $error("write strobe without raised supply");
  AST_SUPPLY_LEAD:
    assert property ($rose(prog_supply_high) |-> (pgm_lo == 1'b0) [*8])
    else $error("strobe too soon after supply");
  AST_PULSE_LEN:
    assert property ($rose(select_and_program_strobe_n) &&
      $past(output_enable_n) |-> pulse_cnt == PULSE_CYC)
    else $error("write pulse length wrong");
  AST_DATA_DRIVE:
    assert property (!mem_dq_oe_n |-> prog_supply_high && output_enable_n)
    else $error("data driven outside write mode");
  AST_SUPPLY_STILL:
    assert property (pgm_lo |-> $stable(prog_supply_high))
    else $error("supply switched under low strobe");
  AST_SIG_ADDR:
    assert property (signature_select_hv && pgm_lo |->
      mem_addr[14:1] == 14'h0 && !output_enable_n)
    else $error("signature address or enable wrong");
  COV_PULSE: cover property ($rose(select_and_program_strobe_n));
  COV_SIG: cover property (signature_select_hv && pgm_lo);
  COV_VFAIL: cover property (rsp_valid && rsp_error);
endmodule
bind uvpc_ctrl uvpc_asserts #(.PULSE_CYC(PULSE_CYC)) uvpc_asserts_inst (
  .clk, .rst_n, .rsp_valid, .rsp_error, .mem_addr,
  .select_and_program_strobe_n, .output_enable_n, .prog_supply_high,
  .signature_select_hv, .mem_dq_oe_n);
`default_nettype wire

// ---- verification/uvpc_mem_model.sv ----
// Behavioural model of the erasable memory at the controller pins.
// Assumes uvpc_ctrl drives the pins; resolves the shared data bus.
`timescale 1ns/100ps
`default_nettype none
module uvpc_mem_model #(
  parameter ACC_NS = 100,
  parameter [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
  parameter [7:0] DEVICE_CODE = 8'h3C // Arbitrary value
) (
  // Control pins
  input wire logic [14:0] mem_addr,
  input wire logic select_and_program_strobe_n,
  input wire logic output_enable_n,
  input wire logic prog_supply_high,
  input wire logic signature_select_hv,
  // Data bus
  input wire logic [7:0] mem_dq_out,
  input wire logic mem_dq_oe_n,
  output logic [7:0] mem_dq_in
);
  logic [7:0] cells [0:32767];
  logic [7:0] last_out = 8'h00;
  logic [7:0] rd;
  logic drive;
  logic drive_d;
  // Blank array reads all ones
  initial begin
    for (int i = 0; i < 32768; i++)
      cells[i] = 8'hFF;
  end
  // Identity codes replace the array
  assign rd = signature_select_hv ?
    (mem_addr[0] ? DEVICE_CODE : MAKER_CODE) : cells[mem_addr];
  // Drive in read or verify only
  assign drive = !output_enable_n &&
    (prog_supply_high || !select_and_program_strobe_n);
  assign #(ACC_NS) drive_d = drive;
  // A floating bus shows the inverse, so stale data never passes
  always @(drive_d or rd)
    if (drive_d)
      last_out = rd;
  assign mem_dq_in = !mem_dq_oe_n ? mem_dq_out : drive_d ? rd : ~last_out;
  // Bits only clear, at the end of a write pulse
  always @(posedge select_and_program_strobe_n)
    if (prog_supply_high && output_enable_n)
      cells[mem_addr] <= cells[mem_addr] & mem_dq_in;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the controller and its memory model.
// Assumes a 100 MHz clock and a shortened write pulse.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int PULSE = 50;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'h3C; // Arbitrary value
  logic clk, rst_n, req_valid, req_ready, rsp_valid, rsp_error;
  logic [1:0] req_op;
  logic [14:0] req_addr, mem_addr;
  logic [7:0] req_wdata, rsp_rdata, mem_dq_out, mem_dq_in;
  logic select_and_program_strobe_n, output_enable_n, mem_dq_oe_n;
  logic prog_supply_high, signature_select_hv;
  int errors, checks;
  uvpc_ctrl #(.PULSE_CYC(PULSE)) uvpc_ctrl_inst (.clk, .rst_n, .req_valid,
    .req_op, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .rsp_error, .mem_addr, .select_and_program_strobe_n, .output_enable_n,
    .prog_supply_high, .signature_select_hv, .mem_dq_out, .mem_dq_oe_n,
    .mem_dq_in);
  uvpc_mem_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    uvpc_mem_model_inst (.mem_addr, .select_and_program_strobe_n,
    .output_enable_n, .prog_supply_high, .signature_select_hv, .mem_dq_out,
    .mem_dq_oe_n, .mem_dq_in);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // Shared request and compare tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One request; waits are bounded so a hang cannot stall the run
  task automatic xfer(input logic [1:0] op, input logic [14:0] a,
      input logic [7:0] d, input logic [7:0] eq, input logic ee);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      $display("mismatch at %0t: request never taken", $time);
    end
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      $display("mismatch at %0t: answer never came", $time);
    end
    check(rsp_rdata, eq);
    check({7'h00, rsp_error}, {7'h00, ee});
  endtask
  task automatic t_erased();
    xfer(2'h0, 15'h7FFF, 8'h00, 8'hFF, 1'b0);
    xfer(2'h0, 15'h0000, 8'h00, 8'hFF, 1'b0);
    $display("test erased done");
  endtask
  task automatic t_program();
    xfer(2'h1, 15'h1234, 8'hA5, 8'hA5, 1'b0);
    xfer(2'h1, 15'h1234, 8'h0F, 8'h0F, 1'b0);
    xfer(2'h0, 15'h1234, 8'h00, 8'h05, 1'b0);
    xfer(2'h0, 15'h1235, 8'h00, 8'hFF, 1'b0);
    $display("test program done");
  endtask
  task automatic t_verify();
    xfer(2'h3, 15'h1234, 8'h05, 8'h05, 1'b0);
    xfer(2'h3, 15'h1234, 8'h06, 8'h05, 1'b1);
    $display("test verify done");
  endtask
  task automatic t_signature();
    xfer(2'h2, 15'h0000, 8'h00, MAKER, 1'b0);
    xfer(2'h2, 15'h7FFF, 8'h00, DEVICE, 1'b0);
    $display("test signature done");
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence after a 20 cycle reset
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = 2'h0;
    req_addr = 15'h0000;
    req_wdata = 8'h00;
    errors = 0;
    checks = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_erased();
    t_program();
    t_verify();
    t_signature();
    results();
  end
  // Watchdog, about four times the expected run
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
